// File: shared/inc_skip_defines.svh
`ifndef INC_SKIP_DEFINES_SVH
`define INC_SKIP_DEFINES_SVH
// How it works
// RULE1: word 0011 11da ffff ffff increments register f, skips on a zero result, keeps flags.
// RULE2: word 0100 10da ffff ffff increments register f, skips on a non-zero result, keeps flags.
// RULE3: destination bit 0 sends the sum to the accumulator, 1 writes it back to register f.
// RULE4: a zero sum of the skip-if-zero form drops the fetched word and runs a no_operation.
// RULE5: a non-zero sum of the skip-if-nonzero form drops the fetched word, runs a no_operation.
// RULE6: access bit 0 takes the access bank, access bit 1 uses bank_select_reg for the bank.
// RULE7: access bit 0, extended set on and f at most 95 selects indexed literal offset mode.
// RULE8: an increment-skip takes one word and 1 cycle, 2 when skipping, 3 over a 2-word one.
// RULE9: every skip cycle does nothing in all four phases, two cycles over a 2-word word.
// RULE10: word 0000 1001 kkkk kkkk ORs the literal into the accumulator and sets N and Z.
// RULE11: the OR uses all eight literal bits, one word, one cycle, result to the accumulator.
// RULE12: the OR decodes in Q1, takes the literal in Q2, works in Q3 and writes in Q4; the code latches the literal with the word in Q1 and ORs in Q4.
// RULE13: a dropped word writes nothing, moves no flag and only advances the program counter.
`define OPC_INC_SZ   6'h0f
`define OPC_INC_SNZ  6'h12
`define OPC_OR_LIT   8'h09
`define BIT_DEST     9
`define BIT_ACCESS   8
`define IDX_MAX      8'h5f
`define LO_PAGE      4'h0
`define HI_PAGE      4'hf
`define ADDR_W       12
`define Q1           2'h0
`define Q2           2'h1
`define Q3           2'h2
`define Q4           2'h3
`define PHASE_DIV    1
`define OFS_ACC      5'h00
`define OFS_BANK     5'h04
`define OFS_CTRL     5'h08
`define OFS_STAT     5'h0c
`define CTRL_RUN     0
`define CTRL_EXT     1
`define STAT_Z       0
`define STAT_N       1
`define STAT_SKIP    2
`define ACC_RST      8'h00
`define BANK_RST     4'h0
`define RUN_RST      1'b1
`define EXT_RST      1'b0
`endif

// File: shared/inc_skip_pkg.sv
package inc_skip_pkg;
   typedef enum logic [1:0] {OP_NONE, OP_INC_SZ, OP_INC_SNZ, OP_OR_LIT} op_e;
   typedef enum logic {ST_EXEC, ST_SKIP} run_e;
   typedef struct packed {
      logic        valid;
      logic [15:0] word;
      logic        two_word;
   } fetch_s;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } mem_req_s;
   typedef struct packed {
      logic [1:0] q;
      logic [7:0] cnt;
   } qgen_s;
   typedef struct packed {
      run_e        st;
      op_e         op;
      logic        took;
      logic [15:0] instr;
      logic [7:0]  opnd;
      logic [7:0]  acc;
      logic [3:0]  bank;
      logic        ext_en;
      logic        run;
      logic        flag_n;
      logic        flag_z;
      logic [1:0]  skip_left;
      logic        skip_first;
      mem_req_s    mem;
      logic        pc_inc;
      logic        flush;
      logic        bus_ack;
      logic [31:0] bus_rdata;
   } core_s;
endpackage

// File: rtl/q_phase_gen.sv
`include "inc_skip_defines.svh"
module q_phase_gen #(
   parameter int PHASE_DIV = `PHASE_DIV
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // phase enable
   output logic            q_en,
   output logic [1:0]      q_idx
);
   localparam logic [7:0] LAST = 8'(PHASE_DIV - 1);
   inc_skip_pkg::qgen_s s_reg;
   inc_skip_pkg::qgen_s s_next;

   if (PHASE_DIV < 1 || PHASE_DIV > 256) begin : g_chk
      $error("PHASE_DIV out of range");
   end

   assign q_en  = (s_reg.cnt == 8'h00);
   assign q_idx = s_reg.q;

   // one enable pulse per phase, phases wrap Q1..Q4
   always_comb begin
      s_next = s_reg;
      if (s_reg.cnt == 8'h00) begin
         s_next.cnt = LAST;
         s_next.q   = s_reg.q + 2'h1;
      end else begin
         s_next.cnt = s_reg.cnt - 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_reg <= '{q: `Q1, cnt: 8'h00};
      end else begin
         s_reg <= s_next;
      end
   end
endmodule // q_phase_gen

// File: rtl/increment_skip_or_literal_exec.sv
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`include "inc_skip_defines.svh"
module increment_skip_or_literal_exec #(
   parameter int PHASE_DIV = `PHASE_DIV
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // avalon-mm slave
   input  wire logic [4:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   // fetch pipeline
   input  wire inc_skip_pkg::fetch_s   fetch,
   output logic                        instr_ready,
   output logic                        pc_inc,
   output logic                        flush,
   // data memory
   input  wire logic [11:0]            idx_base,
   input  wire logic [7:0]             mem_rdata,
   output inc_skip_pkg::mem_req_s      mem
);
   inc_skip_pkg::core_s s_reg;
   inc_skip_pkg::core_s s_next;
   logic                q_en;
   logic [1:0]          q_idx;
   logic [7:0]          sum;
   logic [7:0]          or_val;
   logic                skip_hit;
   logic                bus_req;
   logic                q1_fire;
   logic                q4_fire;

   q_phase_gen #(
      .PHASE_DIV (PHASE_DIV)
   ) u_qgen (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .q_en    (q_en),
      .q_idx   (q_idx)
   );

   // opcode decode
   function automatic inc_skip_pkg::op_e decode(input logic [15:0] w);
      if (w[15:10] == `OPC_INC_SZ) begin
         return inc_skip_pkg::OP_INC_SZ; // RULE1
      end else if (w[15:10] == `OPC_INC_SNZ) begin
         return inc_skip_pkg::OP_INC_SNZ; // RULE2
      end else if (w[15:8] == `OPC_OR_LIT) begin
         return inc_skip_pkg::OP_OR_LIT; // RULE10
      end
      return inc_skip_pkg::OP_NONE;
   endfunction

   function automatic logic is_inc(input inc_skip_pkg::op_e op);
      return op == inc_skip_pkg::OP_INC_SZ || op == inc_skip_pkg::OP_INC_SNZ;
   endfunction

   // operand address from f, access bit and bank
   function automatic logic [11:0] operand_addr(
      input logic [15:0] w,
      input logic        ext,
      input logic [3:0]  bank,
      input logic [11:0] base
   );
      logic [7:0] f;
      f = w[7:0];
      if (w[`BIT_ACCESS]) begin
         return {bank, f}; // RULE6
      end else if (ext && f <= `IDX_MAX) begin
         return 12'(base + {`LO_PAGE, f}); // RULE7
      end else if (f <= `IDX_MAX) begin
         return {`LO_PAGE, f}; // RULE6
      end
      return {`HI_PAGE, f};
   endfunction

   assign q1_fire         = q_en && s_reg.run && (q_idx == `Q1);
   assign q4_fire         = q_en && s_reg.run && (q_idx == `Q4);
   assign sum             = s_reg.opnd + 8'h01;
   assign or_val          = s_reg.acc | s_reg.instr[7:0]; // RULE11
   assign skip_hit        = (s_reg.op == inc_skip_pkg::OP_INC_SZ && sum == 8'h00) ||
                            (s_reg.op == inc_skip_pkg::OP_INC_SNZ && sum != 8'h00);
   assign bus_req         = avs_read || avs_write;
   assign avs_waitrequest = bus_req && !s_reg.bus_ack;
   assign avs_readdata    = s_reg.bus_rdata;
   assign instr_ready     = q1_fire;
   assign pc_inc          = s_reg.pc_inc;
   assign flush           = s_reg.flush;
   assign mem             = s_reg.mem;

   always_comb begin
      s_next        = s_reg;
      s_next.pc_inc = 1'b0;
      s_next.flush  = 1'b0;
      s_next.mem.wr = 1'b0;
      // register slave, one wait state
      s_next.bus_ack   = bus_req && !s_reg.bus_ack;
      s_next.bus_rdata = 32'h0000_0000;
      unique case (avs_address)
         `OFS_ACC:  s_next.bus_rdata[7:0] = s_reg.acc;
         `OFS_BANK: s_next.bus_rdata[3:0] = s_reg.bank;
         `OFS_CTRL: begin
            s_next.bus_rdata[`CTRL_RUN] = s_reg.run;
            s_next.bus_rdata[`CTRL_EXT] = s_reg.ext_en;
         end
         `OFS_STAT: begin
            s_next.bus_rdata[`STAT_Z]    = s_reg.flag_z;
            s_next.bus_rdata[`STAT_N]    = s_reg.flag_n;
            s_next.bus_rdata[`STAT_SKIP] = (s_reg.st == inc_skip_pkg::ST_SKIP);
         end
         default: s_next.bus_rdata = 32'h0000_0000;
      endcase
      if (s_reg.bus_ack && avs_write) begin
         unique case (avs_address)
            `OFS_ACC:  s_next.acc  = avs_writedata[7:0];
            `OFS_BANK: s_next.bank = avs_writedata[3:0];
            `OFS_CTRL: begin
               s_next.run    = avs_writedata[`CTRL_RUN];
               s_next.ext_en = avs_writedata[`CTRL_EXT];
            end
            default: s_next.run = s_reg.run;
         endcase
      end
      // instruction cycle, four phases
      if (q_en && s_reg.run) begin
         unique case (s_reg.st)
            inc_skip_pkg::ST_EXEC: begin
               unique case (q_idx)
                  `Q1: begin
                     s_next.took = fetch.valid;
                     s_next.op   = inc_skip_pkg::OP_NONE;
                     if (fetch.valid) begin
                        s_next.instr = fetch.word;
                        s_next.op    = decode(fetch.word); // RULE12
                        if (is_inc(decode(fetch.word))) begin
                           s_next.mem.rd   = 1'b1;
                           s_next.mem.addr = operand_addr(fetch.word, s_reg.ext_en,
                                                          s_reg.bank, idx_base);
                        end
                     end
                  end
                  `Q2: s_next.mem.rd = s_reg.mem.rd;
                  `Q3: begin
                     s_next.mem.rd = 1'b0;
                     s_next.opnd   = mem_rdata;
                  end
                  `Q4: begin
                     s_next.pc_inc = s_reg.took;
                     if (s_reg.op == inc_skip_pkg::OP_OR_LIT) begin
                        s_next.acc    = or_val; // RULE12
                        s_next.flag_z = (or_val == 8'h00); // RULE10
                        s_next.flag_n = or_val[7]; // RULE10
                     end else if (is_inc(s_reg.op)) begin
                        if (s_reg.instr[`BIT_DEST]) begin
                           s_next.mem.wr    = 1'b1; // RULE3
                           s_next.mem.wdata = sum;
                        end else begin
                           s_next.acc = sum; // RULE3
                        end
                        if (skip_hit) begin
                           s_next.st         = inc_skip_pkg::ST_SKIP; // RULE4 RULE5
                           s_next.flush      = 1'b1;
                           s_next.skip_left  = 2'h1; // RULE8
                           s_next.skip_first = 1'b1;
                        end
                     end
                     s_next.op = inc_skip_pkg::OP_NONE;
                  end
               endcase
            end
            inc_skip_pkg::ST_SKIP: begin
               unique case (q_idx)
                  `Q1: begin
                     if (s_reg.skip_first && fetch.two_word) begin
                        s_next.skip_left = 2'h2; // RULE8 RULE9
                     end
                     s_next.skip_first = 1'b0;
                  end
                  `Q4: begin
                     s_next.pc_inc = 1'b1; // RULE13
                     if (s_reg.skip_left == 2'h1) begin
                        s_next.st = inc_skip_pkg::ST_EXEC;
                     end else begin
                        s_next.skip_left = 2'h1; // RULE9
                     end
                  end
                  default: s_next.skip_left = s_reg.skip_left;
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_reg <= '{st: inc_skip_pkg::ST_EXEC, op: inc_skip_pkg::OP_NONE,
                    acc: `ACC_RST, bank: `BANK_RST, run: `RUN_RST,
                    ext_en: `EXT_RST, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence seq_q4_inc;
      q4_fire && s_reg.st == inc_skip_pkg::ST_EXEC && is_inc(s_reg.op);
   endsequence

   sequence seq_q4_or;
      q4_fire && s_reg.st == inc_skip_pkg::ST_EXEC && s_reg.op == inc_skip_pkg::OP_OR_LIT;
   endsequence

   sequence seq_take_inc;
      q1_fire && s_reg.st == inc_skip_pkg::ST_EXEC && fetch.valid && is_inc(decode(fetch.word));
   endsequence

   a_or_acc_result: assert property ( // RULE11
      seq_q4_or |=> s_reg.acc == ($past(s_reg.acc) | $past(s_reg.instr[7:0])))
      else $error("literal or result wrong");

   a_or_flags_set: assert property ( // RULE10
      seq_q4_or |=> s_reg.flag_z == (s_reg.acc == 8'h00) && s_reg.flag_n == s_reg.acc[7])
      else $error("or flags wrong");

   a_inc_flags_kept: assert property ( // RULE1
      seq_q4_inc |=> $stable(s_reg.flag_z) && $stable(s_reg.flag_n))
      else $error("increment changed flags");

   a_inc_acc_dest: assert property ( // RULE3
      seq_q4_inc ##0 !s_reg.instr[`BIT_DEST] |=>
         s_reg.acc == $past(sum) && !s_reg.mem.wr)
      else $error("increment to accumulator wrong");

   a_inc_mem_dest: assert property ( // RULE3
      seq_q4_inc ##0 s_reg.instr[`BIT_DEST] |=> s_reg.mem.wr && s_reg.mem.wdata == $past(sum))
      else $error("increment write back wrong");

   a_skip_zero_enter: assert property ( // RULE4
      seq_q4_inc ##0 s_reg.op == inc_skip_pkg::OP_INC_SZ && sum == 8'h00 |=>
         s_reg.st == inc_skip_pkg::ST_SKIP && s_reg.flush)
      else $error("skip on zero missed");

   a_skip_nz_enter: assert property ( // RULE5
      seq_q4_inc ##0 s_reg.op == inc_skip_pkg::OP_INC_SNZ |=>
         (s_reg.st == inc_skip_pkg::ST_SKIP) == ($past(sum) != 8'h00))
      else $error("skip on non-zero wrong");

   a_skip_quiet: assert property ( // RULE13
      s_reg.st == inc_skip_pkg::ST_SKIP && $past(s_reg.st) == inc_skip_pkg::ST_SKIP |->
         !s_reg.mem.wr && !s_reg.mem.rd && $stable(s_reg.flag_z) && $stable(s_reg.flag_n) &&
         ($stable(s_reg.acc) || $past(s_reg.bus_ack && avs_write)))
      else $error("skip cycle had an effect");

   a_skip_two_word: assert property ( // RULE9
      q1_fire && s_reg.st == inc_skip_pkg::ST_SKIP && s_reg.skip_first && fetch.two_word |=>
         s_reg.skip_left == 2'h2)
      else $error("second skip cycle missing");

   a_skip_exit: assert property ( // RULE8
      q4_fire && s_reg.st == inc_skip_pkg::ST_SKIP && s_reg.skip_left == 2'h1 |=>
         s_reg.st == inc_skip_pkg::ST_EXEC && s_reg.pc_inc)
      else $error("skip did not end");

   a_bank_addr: assert property ( // RULE6
      seq_take_inc ##0 fetch.word[`BIT_ACCESS] |=>
         s_reg.mem.rd && s_reg.mem.addr == {$past(s_reg.bank), $past(fetch.word[7:0])})
      else $error("banked address wrong");

   a_idx_addr: assert property ( // RULE7
      seq_take_inc ##0 !fetch.word[`BIT_ACCESS] && s_reg.ext_en &&
         fetch.word[7:0] <= `IDX_MAX |=>
         s_reg.mem.addr == 12'($past(idx_base) + {4'h0, $past(fetch.word[7:0])}))
      else $error("indexed address wrong");
endmodule // increment_skip_or_literal_exec

// File: sim/fetch_mem_model.sv
module fetch_mem_model (
   // clock
   input  wire logic                   sys_clk,
   // fetch side
   input  wire logic                   instr_ready,
   input  wire logic                   pc_inc,
   input  wire logic                   flush,
   output inc_skip_pkg::fetch_s        fetch,
   // data memory side
   input  wire inc_skip_pkg::mem_req_s mem,
   output logic [7:0]                  mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] prog [0:7];
   logic        two [0:7];
   logic [7:0]  dmem [0:4095];
   int          ptr = 0;
   int          n = 0;
   int          n_pc = 0;
   int          n_flush = 0;

   initial begin
      for (int i = 0; i < 4096; i++) begin
         dmem[i] = i[7:0] ^ 8'h5a;
      end
      for (int i = 0; i < 8; i++) begin
         two[i] = 1'b0;
         prog[i] = 16'h0000;
      end
   end

   // words past the program end show an inverted pattern
   assign fetch = {ptr < n, (ptr < n) ? prog[ptr[2:0]] : ~prog[ptr[2:0]], two[ptr[2:0]]};
   // read data only valid while read is held
   assign mem_rdata = mem.rd ? dmem[mem.addr] : ~dmem[mem.addr];

   always @(posedge sys_clk) begin
      if (instr_ready && fetch.valid) begin
         ptr <= ptr + 1;
      end
      if (mem.wr) begin
         dmem[mem.addr] <= mem.wdata;
      end
      if (pc_inc) begin
         n_pc <= n_pc + 1;
      end
      if (flush) begin
         n_flush <= n_flush + 1;
      end
   end
endmodule // fetch_mem_model

// File: sim/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   sys_clk;
   logic                   rst_n;
   logic [4:0]             avs_address;
   logic                   avs_read;
   logic                   avs_write;
   logic [31:0]            avs_writedata;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   inc_skip_pkg::fetch_s   fetch;
   logic                   instr_ready;
   logic                   pc_inc;
   logic                   flush;
   logic [11:0]            idx_base;
   logic [7:0]             mem_rdata;
   inc_skip_pkg::mem_req_s mem;
   int                     errors = 0;
   int                     n_compared = 0;
   logic [31:0]            q;
   typedef struct {
      logic [15:0] word;
      logic        ext;
      logic [7:0]  acc0;
      logic [7:0]  init;
      logic [11:0] addr;
      logic [7:0]  acc;
      logic [7:0]  dm;
      logic        fl;
   } row_s;
   row_s rows [7] = '{
      '{16'h3fff, 1'b0, 8'h00, 8'hff, 12'h3ff, 8'h00, 8'h00, 1'b1},
      '{16'h3c10, 1'b0, 8'h00, 8'h41, 12'h010, 8'hc2, 8'h41, 1'b0},
      '{16'h4aa0, 1'b0, 8'h00, 8'h07, 12'hfa0, 8'h00, 8'h08, 1'b1},
      '{16'h4920, 1'b0, 8'h00, 8'hff, 12'h320, 8'h80, 8'hff, 1'b0},
      '{16'h3e5f, 1'b1, 8'h00, 8'h10, 12'h25f, 8'h80, 8'h11, 1'b0},
      '{16'h3e60, 1'b1, 8'h00, 8'h03, 12'hf60, 8'h80, 8'h04, 1'b0},
      '{16'h0935, 1'b1, 8'h9a, 8'h00, 12'h000, 8'hbf, 8'h00, 1'b0}};

   increment_skip_or_literal_exec #(.PHASE_DIV(1)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fetch(fetch), .instr_ready(instr_ready),
      .pc_inc(pc_inc), .flush(flush), .idx_base(idx_base), .mem_rdata(mem_rdata), .mem(mem));

   fetch_mem_model fm (
      .sys_clk(sys_clk), .instr_ready(instr_ready), .pc_inc(pc_inc), .flush(flush),
      .fetch(fetch), .mem(mem), .mem_rdata(mem_rdata));

   task report_and_stop;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      int i;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i >= 50) begin
         errors++;
         report_and_stop;
      end
   endtask

   // offer n program words and let the last instruction finish
   task automatic run(input int n);
      int i;
      fm.ptr <= 0;
      fm.n_pc <= 0;
      fm.n_flush <= 0;
      fm.n <= n;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (fm.ptr < n && i < 200);
      if (i >= 200) begin
         errors++;
         report_and_stop;
      end
      repeat (12) @(posedge sys_clk);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      idx_base = 12'h200;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(1'b1, 5'h04, 32'h3, q);
      foreach (rows[r]) begin
         bus(1'b1, 5'h08, {30'h0, rows[r].ext, 1'b1}, q);
         bus(1'b1, 5'h00, {24'h0, rows[r].acc0}, q);
         fm.dmem[rows[r].addr] = rows[r].init;
         fm.prog[0] = rows[r].word;
         fm.prog[1] = 16'h0980;
         run(2);
         bus(1'b0, 5'h00, 32'h0, q);
         check("acc", q, {24'h0, rows[r].acc});
         check("dmem", {24'h0, fm.dmem[rows[r].addr]}, {24'h0, rows[r].dm});
         check("flush", fm.n_flush, {31'h0, rows[r].fl});
         check("pc_inc", fm.n_pc, 32'h2);
      end
      // skip over a two-word instruction drops both words
      bus(1'b1, 5'h08, 32'h1, q);
      bus(1'b1, 5'h00, 32'h0, q);
      fm.dmem[12'h3ff] = 8'hff;
      fm.prog[0] = 16'h3fff;
      fm.prog[1] = 16'h0901;
      fm.two[1] = 1'b1;
      fm.prog[2] = 16'h0902;
      fm.prog[3] = 16'h0980;
      run(4);
      fm.two[1] = 1'b0;
      bus(1'b0, 5'h00, 32'h0, q);
      check("acc two word", q, 32'h80);
      check("pc_inc two word", fm.n_pc, 32'h4);
      check("flush two word", fm.n_flush, 32'h1);
      // zero and negative flags of the literal or
      bus(1'b1, 5'h00, 32'h0, q);
      fm.prog[0] = 16'h0900;
      run(1);
      bus(1'b0, 5'h0c, 32'h0, q);
      check("flags zero", q, 32'h1);
      fm.prog[0] = 16'h0980;
      run(1);
      bus(1'b1, 5'h0c, 32'h7, q);
      bus(1'b0, 5'h0c, 32'h0, q);
      check("flags negative", q, 32'h2);
      // run cleared freezes the core, the offered word stays untaken
      bus(1'b1, 5'h08, 32'h0, q);
      fm.prog[0] = 16'h0901;
      fm.ptr <= 0;
      fm.n <= 1;
      repeat (12) @(posedge sys_clk);
      check("frozen ptr", fm.ptr, 32'h0);
      bus(1'b1, 5'h08, 32'h1, q);
      run(1);
      bus(1'b0, 5'h00, 32'h0, q);
      check("acc after freeze", q, 32'h81);
      bus(1'b0, 5'h10, 32'h0, q);
      check("unmapped", q, 32'h0);
      // second reset restores register defaults
      bus(1'b1, 5'h08, 32'h3, q);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(1'b0, 5'h00, 32'h0, q);
      check("acc reset", q, 32'h0);
      bus(1'b0, 5'h04, 32'h0, q);
      check("bank reset", q, 32'h0);
      bus(1'b0, 5'h08, 32'h0, q);
      check("ctrl reset", q, 32'h1);
      bus(1'b0, 5'h0c, 32'h0, q);
      check("status reset", q, 32'h0);
      report_and_stop;
   end
endmodule // tb
